// ### pd_power_path_signalling.sv
`timescale 1ns/1ps
// What this block does
// - low on plug detect input qualifies a plug detection; input idles high
// - power enable drives external converter enable only in configurations providing it
// - sink contract ok asserts with valid contract as sink, not vsafe5v-0a
// - contract valid only if its profile is enabled by profile select
// - sink contract ok drops whenever no valid contract exists
// - sink contract ok held low while vbus is outside expected range
// - open-drain fault output pulled low on monitor-detected supply faults
// - external fault input debounced for 1 ms before acting on it
// - three active-low open-drain voltage selects, ordered by increasing voltage
// - with two voltages, select two reserved; low on zero, high on one
// - overvoltage fault when vbus exceeds selected voltage by 10 percent
// - bleed enable asserted during high-to-low vbus transitions
// - bleed enable released when vbus falls to preset percent of destination
// - upstream keep-connected held while vbus in range or transitioning
// - keep-connected behaviour applies to micro-b and micro-a upstream cases
// - in micro-ab pinouts, id indicator low while micro-a plug present
// - charger emulation on at vsafe5v without contract, off with any contract
// - hub enable low turns source power off unless sink under contract
module pd_power_path_signalling #(
    parameter int unsigned DEB_CYC = pd_power_path_pkg::FAULT_DEB_CYC
) (
    // clock and reset
    input  wire logic                                  sys_clk,
    input  wire logic                                  sys_rst,
    // pins from outside
    input  wire logic                                  plug_detect_n,
    input  wire logic                                  fault_in_n,
    input  wire logic                                  hub_port_enable,
    input  wire logic                                  micro_a_present,
    // from policy engine and monitors, same clock
    input  wire pd_power_path_pkg::port_cfg_t          cfg,
    input  wire pd_power_path_pkg::contract_t          contract,
    input  wire logic                                  source_request,
    input  wire logic                                  vsafe5v_no_contract,
    input  wire logic                                  role_swap,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  vbus_voltage_monitor,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  vbus_min_code,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  vbus_max_code,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  code_low,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  code_mid,
    input  wire logic [pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W-1:0]  code_high,
    input  wire logic                                  current_fault,
    // power path outputs
    output logic                                       source_power_enable,
    output logic                                       port_power_enable,
    output logic                                       sink_contract_ok,
    output logic                                       volt_select0_n,
    output logic                                       volt_select1_n,
    output logic                                       volt_select2_n,
    output logic                                       bus_bleed_enable,
    output logic                                       upstream_keep_connected,
    output logic                                       plug_id_indicator,
    output logic                                       charger_emulation_enable,
    output logic                                       fault_n,
    // status back to the policy engine
    output logic                                       plug_detected,
    output logic                                       fault_in_active,
    output logic                                       overvoltage
);

    localparam int unsigned W = pd_power_path_pkg::VBUS_VOLTAGE_MONITOR_W;
    localparam int unsigned CW = $clog2(DEB_CYC + 1);

    initial begin
        if (DEB_CYC < 1) begin
            $error("debounce count must be at least one cycle");
        end
        if (W < 4) begin
            $error("monitor code too narrow for the thresholds");
        end
        if (pd_power_path_pkg::BLEED_PCT < 100) begin
            $error("bleed stop level must not lie below the destination");
        end
    end

    // scale a monitor code by a percentage, widened to avoid overflow
    function automatic logic [W+7:0] pct_of(input logic [W-1:0] code,
                                            input int unsigned pct);
        logic [W+15:0] prod;
        prod = {8'h00, code, 8'h00} >> 8;
        prod = prod * (W+16)'(pct);
        pct_of = (W+8)'(prod / (W+16)'(100));
    endfunction

    // map a voltage index to its monitor code
    function automatic logic [W-1:0] code_of(input pd_power_path_pkg::vsel_t v,
                                             input logic [W-1:0] lo,
                                             input logic [W-1:0] mi,
                                             input logic [W-1:0] hi);
        case (v)
            pd_power_path_pkg::VSEL_LOW:  code_of = lo;
            pd_power_path_pkg::VSEL_MID:  code_of = mi;
            pd_power_path_pkg::VSEL_HIGH: code_of = hi;
            default:                      code_of = '0;
        endcase
    endfunction

    // two-flop synchronisers for pins
    // reset to idle pin levels so no false change follows reset
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_a <= 4'hc;
        end else begin
            sync_a <= {plug_detect_n, fault_in_n, hub_port_enable, micro_a_present};
        end
    end

    // second stage, the only reader of the first
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync_b <= 4'hc;
        end else begin
            sync_b <= sync_a;
        end
    end

    wire plug_n_s  = sync_b[3];
    wire fault_n_s = sync_b[2];
    wire hub_en_s  = sync_b[1];
    wire micro_a_s = sync_b[0];

    // debounce the external fault input; the supplier keeps it valid early
    logic [CW-1:0] deb_cnt;
    logic          fault_in_deb;
    wire           deb_done = (deb_cnt == CW'(DEB_CYC - 1));
    wire           deb_differs = ((!fault_n_s) != fault_in_deb);

    // counts how long the pin has differed from the accepted level
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            deb_cnt <= '0;
        end else if (!deb_differs || deb_done) begin
            deb_cnt <= '0;
        end else begin
            deb_cnt <= deb_cnt + CW'(1);
        end
    end

    // accepts the new level once it has stood the full count
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fault_in_deb <= 1'b0;
        end else if (deb_differs && deb_done) begin
            fault_in_deb <= !fault_n_s;
        end
    end

    // contract qualification against enabled profiles
    wire contract_valid = contract.valid && cfg.profile_mask[contract.profile];
    wire vbus_in_range  = (vbus_voltage_monitor >= vbus_min_code)
                       && (vbus_voltage_monitor <= vbus_max_code);
    wire sink_ok = contract_valid && contract.is_sink && !contract.safe5v_0a
                && vbus_in_range;

    // sourced voltage selection, folded for two-voltage configurations
    wire sourcing = source_request && !plug_n_s;
    wire fold_high = cfg.two_volts && (contract.volt == pd_power_path_pkg::VSEL_HIGH);
    pd_power_path_pkg::vsel_t req_volt;
    assign req_volt = contract_valid ? contract.volt : pd_power_path_pkg::VSEL_LOW;
    pd_power_path_pkg::vsel_t src_volt;
    assign src_volt = !sourcing ? pd_power_path_pkg::VSEL_NONE
                    : fold_high ? pd_power_path_pkg::VSEL_MID
                    : req_volt;
    wire [2:0] vsel_onehot = {src_volt == pd_power_path_pkg::VSEL_HIGH && !cfg.two_volts,
                              src_volt == pd_power_path_pkg::VSEL_MID,
                              src_volt == pd_power_path_pkg::VSEL_LOW};

    // overvoltage against the selected voltage
    wire [W-1:0] sel_code = code_of(src_volt, code_low, code_mid, code_high);
    wire [W+7:0] ovp_lim  = pct_of(sel_code, 100 + pd_power_path_pkg::OVP_PCT);
    wire ovp_now = (src_volt != pd_power_path_pkg::VSEL_NONE)
                && ((W+8)'(vbus_voltage_monitor) > ovp_lim);

    // discharge on high-to-low transitions until near the destination
    pd_power_path_pkg::vsel_t prev_volt;
    logic [W-1:0]             dest_code;
    wire [W+7:0] bleed_lim = pct_of(dest_code, pd_power_path_pkg::BLEED_PCT);
    wire going_down = (src_volt < prev_volt);
    // a destination of none is vsafe0v: stop once vbus is below the valid window
    wire bleed_reached = (dest_code == '0) ? (vbus_voltage_monitor < vbus_min_code)
                       : ((W+8)'(vbus_voltage_monitor) <= bleed_lim);

    // power enable: off when hub enable drops unless sink under contract
    wire hub_off   = !hub_en_s && !(contract_valid && contract.is_sink);
    wire power_on  = cfg.has_power_en && sourcing && !hub_off
                  && !fault_in_deb && !ovp_now;

    // keep-connected on upstream port, also through transitions and swaps
    wire keep_conn = cfg.upstream && (vbus_in_range || bus_bleed_enable || role_swap
                  || upstream_keep_connected && going_down);

    // converter enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            source_power_enable <= pd_power_path_pkg::RST_LOW;
        end else begin
            source_power_enable <= power_on;
        end
    end

    // port power controller enable, same level as the converter enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_power_enable <= pd_power_path_pkg::RST_LOW;
        end else begin
            port_power_enable <= power_on;
        end
    end

    // sink contract flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sink_contract_ok <= pd_power_path_pkg::RST_LOW;
        end else begin
            sink_contract_ok <= sink_ok;
        end
    end

    // lowest voltage select, only while power is on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            volt_select0_n <= pd_power_path_pkg::RST_HIGH;
        end else begin
            volt_select0_n <= !vsel_onehot[0] || !power_on;
        end
    end

    // middle voltage select
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            volt_select1_n <= pd_power_path_pkg::RST_HIGH;
        end else begin
            volt_select1_n <= !vsel_onehot[1] || !power_on;
        end
    end

    // highest voltage select, reserved with two voltages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            volt_select2_n <= pd_power_path_pkg::RST_HIGH;
        end else begin
            volt_select2_n <= !vsel_onehot[2] || !power_on;
        end
    end

    // keep-connected towards the hub
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            upstream_keep_connected <= pd_power_path_pkg::RST_LOW;
        end else begin
            upstream_keep_connected <= keep_conn;
        end
    end

    // plug id towards the otg host
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            plug_id_indicator <= pd_power_path_pkg::RST_HIGH;
        end else begin
            plug_id_indicator <= !(cfg.micro_ab && micro_a_s);
        end
    end

    // charger emulation enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            charger_emulation_enable <= pd_power_path_pkg::RST_LOW;
        end else begin
            charger_emulation_enable <= vsafe5v_no_contract && !contract.valid;
        end
    end

    // open-drain fault data bit, low pulls the line
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fault_n <= pd_power_path_pkg::RST_HIGH;
        end else begin
            fault_n <= !(ovp_now || current_fault);
        end
    end

    // plug status to the policy engine
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            plug_detected <= pd_power_path_pkg::RST_LOW;
        end else begin
            plug_detected <= !plug_n_s;
        end
    end

    // debounced external fault status
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fault_in_active <= pd_power_path_pkg::RST_LOW;
        end else begin
            fault_in_active <= fault_in_deb;
        end
    end

    // overvoltage status
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overvoltage <= pd_power_path_pkg::RST_LOW;
        end else begin
            overvoltage <= ovp_now;
        end
    end

    // previous sourced voltage, to see downward steps
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_volt <= pd_power_path_pkg::VSEL_NONE;
        end else begin
            prev_volt <= src_volt;
        end
    end

    // destination of the current downward step
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dest_code <= '0;
        end else if (going_down) begin
            dest_code <= code_of(src_volt, code_low, code_mid, code_high);
        end
    end

    // bleed from a downward step until near the destination
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bus_bleed_enable <= pd_power_path_pkg::RST_LOW;
        end else if (going_down) begin
            bus_bleed_enable <= 1'b1;
        end else if (bus_bleed_enable && bleed_reached) begin
            bus_bleed_enable <= 1'b0;
        end
    end

endmodule // pd_power_path_signalling

// ### pd_power_path_pkg.sv
package pd_power_path_pkg;

    // clock and debounce timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned FAULT_DEB_US    = 1000;
    localparam int unsigned FAULT_DEB_CYC   = (CLK_HZ / 1_000_000) * FAULT_DEB_US;

    // voltage monitor code width, thresholds in monitor codes
    localparam int unsigned VBUS_VOLTAGE_MONITOR_W          = 12;
    // overvoltage margin in percent above the selected voltage
    localparam int unsigned OVP_PCT         = 10;
    // discharge stops when vbus falls to this percent of the destination
    localparam int unsigned BLEED_PCT       = 110;

    // source voltage index, in order of increasing voltage
    typedef enum logic [1:0] {
        VSEL_NONE,
        VSEL_LOW,
        VSEL_MID,
        VSEL_HIGH
    } vsel_t;

    // contract as reported by the policy engine
    typedef struct packed {
        logic        valid;       // contract established
        logic        is_sink;     // device is sink under the contract
        logic        safe5v_0a;   // contract is the vsafe5v-0a one
        logic [1:0]  profile;     // profile the contract belongs to
        vsel_t       volt;        // negotiated source voltage index
    } contract_t;

    // configuration of this port
    typedef struct packed {
        logic        has_power_en;  // power enable output provided
        logic        upstream;      // upstream-facing port
        logic        micro_ab;      // micro-ab pinout
        logic        two_volts;     // only two source voltages supported
        logic [3:0]  profile_mask;  // profiles enabled by profile select
    } port_cfg_t;

    // reset values of outputs
    localparam logic RST_HIGH = 1'b1;
    localparam logic RST_LOW  = 1'b0;

endpackage

// ### pd_power_path_chk.sv
`timescale 1ns/1ps
module pd_power_path_chk (
    // clock and reset
    input wire logic                         sys_clk,
    input wire logic                         sys_rst,
    // inputs seen by the block
    input wire pd_power_path_pkg::port_cfg_t cfg,
    input wire pd_power_path_pkg::contract_t contract,
    input wire logic                         plug_detect_n,
    input wire logic                         vsafe5v_no_contract,
    // outputs of the block
    input wire logic                         source_power_enable,
    input wire logic                         port_power_enable,
    input wire logic                         sink_contract_ok,
    input wire logic                         volt_select0_n,
    input wire logic                         volt_select1_n,
    input wire logic                         volt_select2_n,
    input wire logic                         charger_emulation_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // selects, power enables, contract flag and charger emulation against their causes
    chk_sel_onehot: assert property (
        $countones(~{volt_select2_n, volt_select1_n, volt_select0_n}) <= 1)
        else $error("more than one voltage select low");
    chk_sel_reserved: assert property (
        cfg.two_volts && $past(cfg.two_volts) |-> volt_select2_n)
        else $error("top voltage select used with two voltages");
    chk_enable_pair: assert property (
        source_power_enable == port_power_enable)
        else $error("power enables disagree");
    chk_no_plug: assert property (
        plug_detect_n [*4] |-> !source_power_enable)
        else $error("power on without plug detect");
    chk_ok_invalid: assert property (
        !contract.valid |=> !sink_contract_ok)
        else $error("contract flag without valid contract");
    chk_ok_safe5v: assert property (
        contract.safe5v_0a |=> !sink_contract_ok)
        else $error("contract flag in vsafe5v-0a contract");
    chk_ok_profile: assert property (
        contract.valid && !cfg.profile_mask[contract.profile] |=> !sink_contract_ok)
        else $error("contract flag for disabled profile");
    chk_emu_on: assert property (
        vsafe5v_no_contract && !contract.valid |=> charger_emulation_enable)
        else $error("charger emulation missing at vsafe5v");
    chk_emu_off: assert property (
        contract.valid |=> !charger_emulation_enable)
        else $error("charger emulation on with contract");
endmodule // pd_power_path_chk

bind pd_power_path_signalling pd_power_path_chk i_chk (.*);

// ### pd_power_path_supply.sv
`timescale 1ns/1ps
module pd_power_path_supply (
    // clock
    input  wire logic        sys_clk,
    // control from the block
    input  wire logic        source_power_enable,
    input  wire logic        volt_select1_n,
    input  wire logic        volt_select2_n,
    input  wire logic        bus_bleed_enable,
    input  wire logic [11:0] code_low,
    input  wire logic [11:0] code_mid,
    input  wire logic [11:0] code_high,
    // far source level and injected offset and fault
    input  wire logic [11:0] host_code,
    input  wire logic [11:0] bump,
    input  wire logic        fault_req,
    // to the block
    output logic [11:0]      vbus_voltage_monitor,
    output logic             fault_in_n
);
    logic [11:0] goal;
    // converter output follows the top and middle selects, else the low code; the far source drives it otherwise
    assign goal = (!volt_select2_n ? code_high : !volt_select1_n ? code_mid : code_low) + bump;
    // fault line valid from time zero, before any enable
    assign fault_in_n = !fault_req;
    initial vbus_voltage_monitor = 12'h000;
    // rise at once, fall fast only while bled; with the enable off, jump straight to the far source level
    always @(posedge sys_clk) begin
        if (!source_power_enable || vbus_voltage_monitor <= goal)
            vbus_voltage_monitor <= source_power_enable ? goal : host_code;
        else if (bus_bleed_enable && vbus_voltage_monitor > goal + 12'h020)
            vbus_voltage_monitor <= vbus_voltage_monitor - 12'h020;
        else
            vbus_voltage_monitor <= vbus_voltage_monitor - 12'h001;
    end
endmodule // pd_power_path_supply

// ### tb_pd_power_path_signalling.sv
`timescale 1ns/1ps
module tb_pd_power_path_signalling;
    typedef struct packed { logic [3:0] id; logic [2:0] val; } note_t;
    logic sys_clk = 0, sys_rst = 1, plug_detect_n = 1, hub_port_enable = 0, fault_req = 0;
    logic micro_a_present = 0, source_request = 0, vsafe5v_no_contract = 0, role_swap = 0;
    logic current_fault = 0, fault_in_n, source_power_enable, port_power_enable;
    logic sink_contract_ok, bus_bleed_enable, volt_select0_n, volt_select1_n, volt_select2_n;
    logic upstream_keep_connected, plug_id_indicator, charger_emulation_enable, fault_n;
    logic plug_detected, fault_in_active, overvoltage;
    logic [11:0] vbus_voltage_monitor, vbus_min_code = 12'h1C2, vbus_max_code = 12'h898;
    logic [11:0] code_low = 12'h1F4, code_mid = 12'h4B0, code_high = 12'h7D0;
    logic [11:0] host_code = 12'h1F4, bump = 12'h000;
    logic [15:0] lfsr = 16'h189B;
    logic [11:0] flags;
    pd_power_path_pkg::port_cfg_t cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 4'hF};
    pd_power_path_pkg::contract_t contract = '0;
    int error_cnt = 0, comparisons = 0;
    note_t notes[$];
    note_t cur;
    event chk_ev;

    always #10 sys_clk = ~sys_clk;
    pd_power_path_signalling #(.DEB_CYC(8)) i_dut (.*);
    pd_power_path_supply i_far (.*);
    // observed outputs, indexed by note id
    assign flags = {plug_detected, port_power_enable,
                    overvoltage, fault_in_active, fault_n, charger_emulation_enable,
                    plug_id_indicator, upstream_keep_connected, bus_bleed_enable,
                    sink_contract_ok, 1'b0, source_power_enable};

    function automatic logic [2:0] obs(input logic [3:0] id);
        return (id == 4'h1) ? {volt_select2_n, volt_select1_n, volt_select0_n} : {2'b00, flags[id]};
    endfunction
    function automatic logic [15:0] next_lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic note_exp(input logic [3:0] id, input logic [2:0] v);
        notes.push_back({id, v});
        -> chk_ev;
        #1;
    endtask
    task automatic wait_exp(input logic [3:0] id, input logic [2:0] v, input int n);
        for (int i = 0; i < n && obs(id) !== v; i++) step(1);
        note_exp(id, v);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // takes the oldest note and compares it with the output it names
    initial forever begin
        @(chk_ev);
        cur = notes.pop_front();
        comparisons++;
        if (obs(cur.id) !== cur.val) begin
            error_cnt++;
            $display("[ERR] %0t id %0h exp %0h got %0h", $time, cur.id, cur.val, obs(cur.id));
        end
    end

    // watchdog well beyond the expected run length
    initial begin
        #400000;
        error_cnt++;
        stop_test;
    end

    // main sequence
    initial begin
        step(8);
        sys_rst = 0;
        plug_detect_n = 0;
        hub_port_enable = 1;
        source_request = 1;
        contract = '{1'b1, 1'b0, 1'b0, 2'h0, pd_power_path_pkg::VSEL_LOW};
        step(4);
        note_exp(0, 1);
        note_exp(10, 1);
        note_exp(11, 1);
        for (int v = 1; v < 4; v++) begin
            contract.volt = pd_power_path_pkg::vsel_t'(v);
            step(2);
            note_exp(1, ~(3'b001 << (v - 1)));
        end
        contract.volt = pd_power_path_pkg::VSEL_LOW;
        step(2);
        note_exp(3, 1);
        note_exp(4, 1);
        wait_exp(3, 0, 100);
        $display("sourcing and bleed test done");
        bump = 12'h032;
        step(4);
        note_exp(9, 0);
        bump = 12'h033;
        wait_exp(9, 1, 8);
        note_exp(7, 0);
        bump = 12'h000;
        wait_exp(9, 0, 100);
        current_fault = 1;
        step(2);
        note_exp(7, 0);
        current_fault = 0;
        step(2);
        note_exp(7, 1);
        cfg.two_volts = 1;
        contract.volt = pd_power_path_pkg::VSEL_HIGH;
        wait_exp(1, 3'b101, 8);
        cfg.two_volts = 0;
        hub_port_enable = 0;
        step(4);
        note_exp(0, 0);
        hub_port_enable = 1;
        wait_exp(0, 1, 8);
        $display("overvoltage and enable test done");
        fault_req = 1;
        step(4);
        fault_req = 0;
        step(8);
        note_exp(8, 0);
        fault_req = 1;
        step(8);
        note_exp(8, 0);
        wait_exp(8, 1, 6);
        wait_exp(0, 0, 3);
        fault_req = 0;
        wait_exp(8, 0, 20);
        $display("fault input test done");
        source_request = 0;
        for (int i = 0; i < 16; i++) begin
            contract = '{i[3], 1'b1, i[2], 2'h1, pd_power_path_pkg::VSEL_LOW};
            cfg.profile_mask = i[1] ? 4'hF : 4'hD;
            host_code = i[0] ? 12'h9C4 : 12'h1F4;
            step(3);
            note_exp(2, {2'b00, i[3] & ~i[2] & i[1] & ~i[0]});
        end
        $display("sink contract test done");
        for (int i = 0; i < 8; i++) begin
            lfsr = next_lfsr(lfsr);
            vsafe5v_no_contract = lfsr[0];
            contract.valid = lfsr[1];
            micro_a_present = lfsr[2];
            step(4);
            note_exp(6, {2'b00, lfsr[0] & ~lfsr[1]});
            note_exp(5, {2'b00, ~lfsr[2]});
        end
        host_code = 12'h12C;
        role_swap = 1;
        micro_a_present = 1;
        step(4);
        note_exp(4, 1);
        role_swap = 0;
        step(4);
        note_exp(4, 0);
        plug_detect_n = 1;
        step(4);
        note_exp(11, 0);
        $display("emulation, id and keep test done");
        stop_test;
    end
endmodule // tb_pd_power_path_signalling
